// ==== reset_init_assertions.sv ====
// Purpose: Assertions on reset-cause effects and register bus answers
// Assumes: Cause inputs are held high for at least two cycles
// Notes: Windows of two to four edges cover the two-flop synchroniser
`timescale 1ns/1ps
// ----------------
// Checker
// ----------------
module reset_init_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic por_req,
    input wire logic brownout_reset,
    input wire logic external_reset_pin,
    input wire logic watchdog_timer,
    input wire logic wake_irq,
    input wire logic wake_wdt,
    input wire logic [12:0] sleep_pc,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic [12:0] program_counter,
    input wire logic [7:0] timer2_period,
    input wire logic [7:0] port_a_direction,
    input wire logic [7:0] port_b_direction,
    input wire logic [7:0] option_control,
    input wire logic [5:0] last_cause
);
    // No reset source active, so a wake is not hidden by priority
    logic calm;
    assign calm = !por_req && !brownout_reset && !external_reset_pin && !watchdog_timer;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Cause effects
    por_values_a: assert property ($rose(por_req) |-> ##[2:4]
        (last_cause == 6'h02 && option_control == 8'hff && port_a_direction == 8'hff
        && port_b_direction == 8'hff && timer2_period == 8'hff))
        else $error("power-on values not applied");
    other_ones_a: assert property ($rose(external_reset_pin) && !por_req && !brownout_reset
        |-> ##[2:4] (last_cause == 6'h04 && program_counter == 13'h0000
        && option_control == 8'hff && port_b_direction == 8'hff))
        else $error("other reset values not applied");
    brown_cause_a: assert property ($rose(brownout_reset) && !por_req |-> ##[2:4]
        (last_cause == 6'h08 && timer2_period == 8'hff))
        else $error("brown-out cause not recorded");
    wdt_wake_a: assert property ($rose(wake_wdt) && calm && !wake_irq |-> ##[2:4]
        (program_counter == sleep_pc + 13'h1 && last_cause == 6'h20))
        else $error("watchdog wake pc wrong");
    irq_wake_a: assert property ($rose(wake_irq) && calm |-> ##[2:4] (last_cause == 6'h10
        && (program_counter == 13'h0004 || program_counter == sleep_pc + 13'h1)))
        else $error("interrupt wake pc wrong");
    wake_hold_a: assert property (($rose(wake_irq) || $rose(wake_wdt)) && calm |=>
        ($stable(option_control) && $stable(port_a_direction) && $stable(timer2_period))[*4])
        else $error("wake changed a held register");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    cause_onehot_a: assert property ($onehot(last_cause))
        else $error("cause not one-hot");

    // Bus answers
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property ($rose(s_axi_arvalid) |-> ##[1:2] s_axi_rvalid)
        else $error("read answer late");
endmodule : reset_init_checker

bind reset_init_register_state reset_init_checker i_chk (.*);

// ==== reset_init_defines.svh ====
// Purpose: Constants for the reset-dependent register bank
// Assumes: Byte offsets are the printed register numbers times four
// Notes: Values are eight bits wide; unimplemented bits are masked to zero
`ifndef RESET_INIT_DEFINES_SVH
`define RESET_INIT_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define IDX_INTERRUPT_CONTROL_REG_REG 8'h0b
`define IDX_PIR_FLAGS 8'h0c
`define IDX_TIMER1_CTL 8'h10
`define IDX_T2CTL 8'h12
`define IDX_CC_LOW 8'h15
`define IDX_CC_HIGH 8'h16
`define IDX_CC_CTL 8'h17
`define IDX_RX_STATUS 8'h18
`define IDX_TX_BUF 8'h19
`define IDX_RX_BUF 8'h1a
`define IDX_CMP_CTL 8'h1f
`define IDX_OPT_CTL 8'h81
`define IDX_DIR_A 8'h85
`define IDX_DIR_B 8'h86
`define IDX_PIE 8'h8c
`define IDX_PWR_CTL 8'h8e
`define IDX_T2PER 8'h92
`define IDX_TX_STATUS 8'h98
`define IDX_BAUD 8'h99
`define IDX_NVM_DATA 8'h9a
`define IDX_NVM_ADDR 8'h9b
`define IDX_NVM_CTL1 8'h9c
`define IDX_NVM_CTL2 8'h9d
`define IDX_VREF_CTL 8'h9f
`define IDX_CAUSE 8'hf0
`define IDX_RESUME_PC 8'hf1

// ----------------------------------------------------------------
// Masks of implemented bits and reset values
// ----------------------------------------------------------------
`define MASK_T2CTL 8'h7f
`define MASK_SIX 8'h3f
`define MASK_PIR 8'hf7
`define MASK_PWR 8'h0b
`define MASK_TXS 8'hf7
`define MASK_NVM1 8'h0f
`define MASK_VREF 8'hef
`define VAL_ONES 8'hff
`define VAL_ZERO 8'h00
`define VAL_TXS 8'h02
`define VAL_PWR_POR 8'h08
`define VAL_PWR_OTHER 8'h08
`define BIT_PWR_BROWN 0
`define BIT_GIE 7
`define BIT_NVM_ERR 3
`define VEC_RESET 13'h0000
`define VEC_IRQ 13'h0004
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== reset_init_pkg.sv ====
// Purpose: Types for the reset-dependent register bank
// Assumes: Constants live in reset_init_defines.svh
// Notes: Cause codes are one-hot
package reset_init_pkg;

    // Reset or wake cause, one-hot
    typedef enum logic [5:0] {
        cause_none = 6'h01,
        cause_por = 6'h02,
        cause_other = 6'h04,
        cause_brown = 6'h08,
        cause_wake_irq = 6'h10,
        cause_wake_wdt = 6'h20
    } cause_t;

    typedef struct packed {
        logic [7:0] interrupt_control_reg;
        logic [7:0] pir;
        logic [7:0] timer1_control;
        logic [7:0] timer2_control;
        logic [7:0] cc_low;
        logic [7:0] cc_high;
        logic [7:0] cc_ctl;
        logic [7:0] rx_status;
        logic [7:0] tx_buf;
        logic [7:0] rx_buf;
        logic [7:0] cmp_ctl;
        logic [7:0] opt_ctl;
        logic [7:0] dir_a;
        logic [7:0] dir_b;
        logic [7:0] pie;
        logic [7:0] pwr;
        logic [7:0] t2per;
        logic [7:0] tx_status;
        logic [7:0] baud;
        logic [7:0] nvm_data;
        logic [7:0] nvm_addr;
        logic [7:0] nvm_ctl1;
        logic [7:0] vref;
        logic [12:0] pc;
        cause_t cause;
        logic aw_full;
        logic [7:0] aw_idx;
        logic aw_ok;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

endpackage : reset_init_pkg

// ==== reset_init_register_state.sv ====
// Purpose: Register bank whose contents are set by the kind of reset or wake-up
// Assumes: Reset and wake requests are asynchronous one-cycle-or-longer levels
// Notes: Registers are reached over AXI4-Lite, one aligned word each
//
// Functional notes
// (RULE1) Interrupt wake with global enable loads 0004h
// (RULE2) Brown-out clears power bit 0, sets bit 3, others keep
// (RULE3) Brown-out forces timer1 control to zero
// (RULE4) Interrupt wake sets the causing flag bits
// (RULE5) Waking peripheral updates its status bits
// (RULE6) Power-on applies power-on values to all but cc_low, cc_high, nvm_data, nvm_addr
// (RULE7) Option, directions, period ones on resets
// (RULE8) Unchanged kept, unimplemented bits read zero
// (RULE9) Cause recorded, selects one value column
`timescale 1ns/1ps
`include "reset_init_defines.svh"

module reset_init_register_state
    import reset_init_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic por_req,
    input wire logic brownout_reset,
    input wire logic external_reset_pin,
    input wire logic watchdog_timer,
    input wire logic wake_irq,
    input wire logic wake_wdt,
    input wire logic [7:0] wake_interrupt_control_reg_flags,
    input wire logic [7:0] wake_pir_flags,
    input wire logic [12:0] sleep_pc,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [12:0] program_counter,
    output logic [7:0] timer2_period,
    output logic [7:0] port_a_direction,
    output logic [7:0] port_b_direction,
    output logic [7:0] option_control,
    output logic [5:0] last_cause
);

    state_t cur;
    state_t nxt;
    logic [5:0] raw_req;
    logic [5:0] meta_req;
    logic [5:0] sync_req;
    logic [5:0] sync_old;
    logic [5:0] req_rise;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Valid word index from a byte address, or all ones when misaligned or above byte 3FFh
    function automatic logic [8:0] word_index(input logic [31:0] addr);
        if (addr[1:0] != 2'b00 || addr[31:10] != 22'h0)
            return 9'h1ff;
        return {1'b0, addr[9:2]};
    endfunction : word_index

    // True when the index names a mapped register
    function automatic logic is_mapped(input logic [8:0] idx);
        case (idx[7:0])
            `IDX_INTERRUPT_CONTROL_REG_REG, `IDX_PIR_FLAGS, `IDX_TIMER1_CTL, `IDX_T2CTL,
            `IDX_CC_LOW, `IDX_CC_HIGH, `IDX_CC_CTL, `IDX_RX_STATUS,
            `IDX_TX_BUF, `IDX_RX_BUF, `IDX_CMP_CTL, `IDX_OPT_CTL,
            `IDX_DIR_A, `IDX_DIR_B, `IDX_PIE, `IDX_PWR_CTL, `IDX_T2PER,
            `IDX_TX_STATUS, `IDX_BAUD, `IDX_NVM_DATA, `IDX_NVM_ADDR,
            `IDX_NVM_CTL1, `IDX_NVM_CTL2, `IDX_VREF_CTL, `IDX_CAUSE,
            `IDX_RESUME_PC: return !idx[8];
            default: return 1'b0;
        endcase
    endfunction : is_mapped

    // Read value of one register; unimplemented bits come back zero
    function automatic logic [7:0] read_reg(input state_t s, input logic [7:0] idx);
        case (idx)
            `IDX_INTERRUPT_CONTROL_REG_REG: return s.interrupt_control_reg;
            `IDX_PIR_FLAGS: return s.pir & `MASK_PIR; // RULE8
            `IDX_TIMER1_CTL: return s.timer1_control & `MASK_SIX; // RULE8
            `IDX_T2CTL: return s.timer2_control & `MASK_T2CTL; // RULE8
            `IDX_CC_LOW: return s.cc_low;
            `IDX_CC_HIGH: return s.cc_high;
            `IDX_CC_CTL: return s.cc_ctl & `MASK_SIX;
            `IDX_RX_STATUS: return s.rx_status;
            `IDX_RX_BUF: return s.rx_buf;
            `IDX_CMP_CTL: return s.cmp_ctl;
            `IDX_OPT_CTL: return s.opt_ctl;
            `IDX_DIR_A: return s.dir_a;
            `IDX_DIR_B: return s.dir_b;
            `IDX_PIE: return s.pie & `MASK_PIR;
            `IDX_PWR_CTL: return s.pwr & `MASK_PWR;
            `IDX_T2PER: return s.t2per;
            `IDX_TX_STATUS: return s.tx_status & `MASK_TXS;
            `IDX_BAUD: return s.baud;
            `IDX_NVM_DATA: return s.nvm_data;
            `IDX_NVM_ADDR: return s.nvm_addr;
            `IDX_NVM_CTL1: return s.nvm_ctl1 & `MASK_NVM1;
            `IDX_VREF_CTL: return s.vref & `MASK_VREF;
            `IDX_CAUSE: return {2'b00, s.cause};
            `IDX_RESUME_PC: return s.pc[7:0];
            default: return `VAL_ZERO;
        endcase
    endfunction : read_reg

    // Byte lane zero merge under strobe
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
        return strb[0] ? d[7:0] : old;
    endfunction : merge

    // ----------------------------------------------------------------
    // Cause inputs: two-stage synchronisers, then edge detection
    // ----------------------------------------------------------------
    assign raw_req = {wake_wdt, wake_irq, brownout_reset, external_reset_pin | watchdog_timer,
                      por_req, 1'b0};

    // Sync flops live outside the struct; the first stage is read only by the second
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_req <= 6'h00;
            sync_req <= 6'h00;
            sync_old <= 6'h00;
        end
        else
        begin
            meta_req <= raw_req;
            sync_req <= meta_req;
            sync_old <= sync_req;
        end
    end

    assign req_rise = sync_req & ~sync_old;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------

    // Priority: power-on over brown-out over other resets over wakes
    always_comb
    begin
        logic [8:0] widx;
        logic [7:0] wd;
        nxt = cur;
        widx = 9'h000;
        wd = `VAL_ZERO;
        if (req_rise[1])
        begin
            // Power-on values on every register but cc_low, cc_high, nvm_data, nvm_addr
            nxt.cause = cause_por; // RULE9
            nxt.interrupt_control_reg = `VAL_ZERO; // RULE6
            nxt.pir = `VAL_ZERO;
            nxt.timer1_control = `VAL_ZERO;
            nxt.timer2_control = `VAL_ZERO;
            nxt.cc_ctl = `VAL_ZERO;
            nxt.rx_status = `VAL_ZERO;
            nxt.tx_buf = `VAL_ZERO;
            nxt.rx_buf = `VAL_ZERO;
            nxt.cmp_ctl = `VAL_ZERO;
            nxt.pie = `VAL_ZERO;
            nxt.tx_status = `VAL_TXS;
            nxt.baud = `VAL_ZERO;
            nxt.vref = `VAL_ZERO;
            nxt.nvm_ctl1 = `VAL_ZERO;
            nxt.pwr = `VAL_PWR_POR; // RULE6
            nxt.opt_ctl = `VAL_ONES; // RULE7
            nxt.dir_a = `VAL_ONES; // RULE7
            nxt.dir_b = `VAL_ONES; // RULE7
            nxt.t2per = `VAL_ONES; // RULE7
            nxt.pc = `VEC_RESET;
        end
        else if (req_rise[2] || req_rise[3])
        begin
            // Other-reset column; data-like registers stay unchanged
            nxt.cause = req_rise[3] ? cause_brown : cause_other; // RULE9
            nxt.interrupt_control_reg = {7'h00, cur.interrupt_control_reg[0]};
            nxt.pir = `VAL_ZERO;
            nxt.timer2_control = `VAL_ZERO;
            nxt.cc_ctl = `VAL_ZERO;
            nxt.rx_status = {7'h00, cur.rx_status[0]};
            nxt.tx_buf = `VAL_ZERO;
            nxt.rx_buf = `VAL_ZERO;
            nxt.cmp_ctl = `VAL_ZERO;
            nxt.pie = `VAL_ZERO;
            nxt.tx_status = `VAL_TXS;
            nxt.baud = `VAL_ZERO;
            nxt.vref = `VAL_ZERO;
            nxt.nvm_ctl1 = {4'h0, cur.nvm_ctl1[3], 3'b000};
            nxt.opt_ctl = `VAL_ONES; // RULE7
            nxt.dir_a = `VAL_ONES; // RULE7
            nxt.dir_b = `VAL_ONES; // RULE7
            nxt.t2per = `VAL_ONES; // RULE7
            nxt.pwr = cur.pwr | `VAL_PWR_OTHER; // RULE8
            nxt.pc = `VEC_RESET;
            if (req_rise[3])
            begin
                nxt.pwr[`BIT_PWR_BROWN] = 1'b0; // RULE2
                nxt.timer1_control = `VAL_ZERO; // RULE3
            end
        end
        else if (req_rise[4] || req_rise[5])
        begin
            // Wake column: everything unchanged except cause, flags, two status bits and PC
            nxt.cause = req_rise[4] ? cause_wake_irq : cause_wake_wdt; // RULE9
            nxt.pc = sleep_pc + 13'h0001; // RULE8
            if (req_rise[4])
            begin
                nxt.interrupt_control_reg = cur.interrupt_control_reg | wake_interrupt_control_reg_flags; // RULE4
                nxt.pir = (cur.pir | wake_pir_flags) & `MASK_PIR; // RULE4
                // Receive flag also marks receive status valid
                if (wake_pir_flags[5])
                    nxt.rx_status[0] = 1'b1; // RULE5
                if (wake_pir_flags[7])
                    nxt.nvm_ctl1[`BIT_NVM_ERR] = 1'b0; // RULE5
                if (cur.interrupt_control_reg[`BIT_GIE])
                    nxt.pc = `VEC_IRQ; // RULE1
            end
        end

        // Bus write address and data may arrive in either order
        if (s_axi_awvalid && !cur.aw_full)
        begin
            widx = word_index(s_axi_awaddr);
            nxt.aw_full = 1'b1;
            nxt.aw_idx = widx[7:0];
            nxt.aw_ok = is_mapped(widx);
        end
        if (s_axi_wvalid && !cur.w_full)
        begin
            nxt.w_full = 1'b1;
            nxt.w_data = s_axi_wdata;
            nxt.w_strb = s_axi_wstrb;
        end
        // A reset event in the same cycle wins over a software write
        if (cur.aw_full && cur.w_full && !cur.bvalid)
        begin
            nxt.aw_full = 1'b0;
            nxt.w_full = 1'b0;
            nxt.bvalid = 1'b1;
            nxt.bresp = cur.aw_ok ? `RESP_OKAY : `RESP_SLVERR;
            if (cur.aw_ok && req_rise[5:1] == 5'h00)
            begin
                case (cur.aw_idx)
                    `IDX_INTERRUPT_CONTROL_REG_REG: nxt.interrupt_control_reg = merge(cur.interrupt_control_reg, cur.w_data, cur.w_strb);
                    `IDX_PIR_FLAGS: nxt.pir = merge(cur.pir, cur.w_data, cur.w_strb);
                    `IDX_TIMER1_CTL: nxt.timer1_control = merge(cur.timer1_control, cur.w_data, cur.w_strb);
                    `IDX_T2CTL: nxt.timer2_control = merge(cur.timer2_control, cur.w_data, cur.w_strb);
                    `IDX_CC_LOW: nxt.cc_low = merge(cur.cc_low, cur.w_data, cur.w_strb);
                    `IDX_CC_HIGH: nxt.cc_high = merge(cur.cc_high, cur.w_data, cur.w_strb);
                    `IDX_CC_CTL: nxt.cc_ctl = merge(cur.cc_ctl, cur.w_data, cur.w_strb);
                    `IDX_RX_STATUS: nxt.rx_status = merge(cur.rx_status, cur.w_data, cur.w_strb);
                    `IDX_TX_BUF: nxt.tx_buf = merge(cur.tx_buf, cur.w_data, cur.w_strb);
                    `IDX_CMP_CTL: nxt.cmp_ctl = merge(cur.cmp_ctl, cur.w_data, cur.w_strb);
                    `IDX_OPT_CTL: nxt.opt_ctl = merge(cur.opt_ctl, cur.w_data, cur.w_strb);
                    `IDX_DIR_A: nxt.dir_a = merge(cur.dir_a, cur.w_data, cur.w_strb);
                    `IDX_DIR_B: nxt.dir_b = merge(cur.dir_b, cur.w_data, cur.w_strb);
                    `IDX_PIE: nxt.pie = merge(cur.pie, cur.w_data, cur.w_strb);
                    `IDX_PWR_CTL: nxt.pwr = merge(cur.pwr, cur.w_data, cur.w_strb);
                    `IDX_T2PER: nxt.t2per = merge(cur.t2per, cur.w_data, cur.w_strb);
                    `IDX_TX_STATUS: nxt.tx_status = merge(cur.tx_status, cur.w_data, cur.w_strb);
                    `IDX_BAUD: nxt.baud = merge(cur.baud, cur.w_data, cur.w_strb);
                    `IDX_NVM_DATA: nxt.nvm_data = merge(cur.nvm_data, cur.w_data, cur.w_strb);
                    `IDX_NVM_ADDR: nxt.nvm_addr = merge(cur.nvm_addr, cur.w_data, cur.w_strb);
                    `IDX_NVM_CTL1: nxt.nvm_ctl1 = merge(cur.nvm_ctl1, cur.w_data, cur.w_strb);
                    `IDX_VREF_CTL: nxt.vref = merge(cur.vref, cur.w_data, cur.w_strb);
                    default: wd = `VAL_ZERO; // Write-only strobe or read-only: dropped
                endcase
            end
        end
        if (cur.bvalid && s_axi_bready)
            nxt.bvalid = 1'b0;

        // Read: one-cycle address acceptance, data valid from the same edge
        nxt.arready = 1'b0;
        if (s_axi_arvalid && !cur.arready && !cur.rvalid)
        begin
            widx = word_index(s_axi_araddr);
            nxt.arready = 1'b1;
            nxt.rvalid = 1'b1;
            nxt.rresp = is_mapped(widx) ? `RESP_OKAY : `RESP_SLVERR;
            nxt.rdata = {24'h000000, is_mapped(widx) ? read_reg(cur, widx[7:0]) : wd}; // RULE8
        end
        else if (cur.rvalid && s_axi_rready)
            nxt.rvalid = 1'b0;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------

    // Hardware reset loads power-on values with cause_none: all known values
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur <= '0;
            cur.cause <= cause_none;
            cur.opt_ctl <= `VAL_ONES;
            cur.dir_a <= `VAL_ONES;
            cur.dir_b <= `VAL_ONES;
            cur.t2per <= `VAL_ONES;
            cur.tx_status <= `VAL_TXS;
            cur.pwr <= `VAL_PWR_POR;
        end
        else
            cur <= nxt;
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flops
    // ----------------------------------------------------------------
    assign s_axi_awready = !cur.aw_full;
    assign s_axi_wready = !cur.w_full;
    assign s_axi_bvalid = cur.bvalid;
    assign s_axi_bresp = cur.bresp;
    assign s_axi_arready = cur.arready;
    assign s_axi_rvalid = cur.rvalid;
    assign s_axi_rdata = cur.rdata;
    assign s_axi_rresp = cur.rresp;
    assign program_counter = cur.pc;
    assign timer2_period = cur.t2per;
    assign port_a_direction = cur.dir_a;
    assign port_b_direction = cur.dir_b;
    assign option_control = cur.opt_ctl;
    assign last_cause = cur.cause;

endmodule : reset_init_register_state

// ==== test_reset_init_register_state.sv ====
// Purpose: Self-checking bench for the reset-dependent register bank
// Assumes: Cause inputs held four cycles, then low six, before checking
// Notes: Registers are reached through the AXI4-Lite tasks and the direct output ports
`timescale 1ns/1ps
`include "reset_init_defines.svh"
module test_reset_init_register_state;
    logic clock, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic por_req, brownout_reset, external_reset_pin, watchdog_timer, wake_irq, wake_wdt;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] wake_interrupt_control_reg_flags, wake_pir_flags, timer2_period, option_control;
    logic [7:0] port_a_direction, port_b_direction;
    logic [12:0] sleep_pc, program_counter;
    logic [5:0] last_cause, ev;
    int err_total, checked;

    // Cause sources as one vector: por, brown, ext, wdt reset, irq wake, wdt wake
    assign {wake_wdt, wake_irq, watchdog_timer, external_reset_pin, brownout_reset, por_req} = ev;

    reset_init_register_state i_dut (.*);

    // ----------------
    // Shared tasks
    // ----------------
    task automatic check(input bit ok, input string msg);
        checked++;
        if (!ok)
        begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : check

    // Address and data offered together, each released when taken
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr <= {22'h0, idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while ((s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid) && n < 50)
        begin
            @(posedge clock);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        check(s_axi_bresp === er && n < 50, "write response");
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= {22'h0, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end while (!s_axi_rvalid && n < 50);
        check(s_axi_rdata === {24'h0, exp} && s_axi_rresp === er && n < 50, "read data");
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask : rd

    // Six idle edges let the synchroniser and the update land
    task automatic fire(input logic [5:0] m);
        ev <= m;
        repeat (4) @(posedge clock);
        ev <= 6'h00;
        repeat (6) @(posedge clock);
    endtask : fire

    // ----------------
    // Scenarios
    // ----------------
    task automatic t_after_reset();
        rd(`IDX_OPT_CTL, 8'hff, 2'b00);
        rd(`IDX_DIR_B, 8'hff, 2'b00);
        rd(`IDX_TX_STATUS, 8'h02, 2'b00);
        rd(`IDX_PWR_CTL, 8'h08, 2'b00);
        rd(`IDX_CAUSE, 8'h01, 2'b00);
    endtask : t_after_reset

    // Unmapped place refused, unimplemented bits read zero
    task automatic t_refuse();
        rd(8'h40, 8'h00, 2'b10);
        wr(8'h40, 8'h55, 2'b10);
        wr(`IDX_NVM_CTL2, 8'h00, 2'b00);
        wr(`IDX_TIMER1_CTL, 8'hff, 2'b00);
        rd(`IDX_TIMER1_CTL, 8'h3f, 2'b00);
        wr(`IDX_T2CTL, 8'hff, 2'b00);
        rd(`IDX_T2CTL, 8'h7f, 2'b00);
    endtask : t_refuse

    // External and watchdog resets share one column; timer1 control is kept
    task automatic t_other_reset();
        for (int i = 0; i < 2; i++)
        begin
            wr(`IDX_OPT_CTL, 8'h5a, 2'b00);
            wr(`IDX_T2PER, 8'h12, 2'b00);
            fire(i ? 6'h08 : 6'h04);
            check(program_counter === 13'h0000 && last_cause === 6'h04, "other cause");
            rd(`IDX_OPT_CTL, 8'hff, 2'b00);
            rd(`IDX_T2PER, 8'hff, 2'b00);
            rd(`IDX_T2CTL, 8'h00, 2'b00);
            rd(`IDX_TIMER1_CTL, 8'h3f, 2'b00);
        end
    endtask : t_other_reset

    task automatic t_brownout();
        wr(`IDX_PWR_CTL, 8'h03, 2'b00);
        fire(6'h02);
        check(last_cause === 6'h08, "brown cause");
        rd(`IDX_TIMER1_CTL, 8'h00, 2'b00);
        rd(`IDX_PWR_CTL, 8'h0a, 2'b00);
        wr(`IDX_PWR_CTL, 8'h01, 2'b00);
        fire(6'h04);
        rd(`IDX_PWR_CTL, 8'h09, 2'b00);
    endtask : t_brownout

    task automatic t_power_on();
        wr(`IDX_DIR_A, 8'h00, 2'b00);
        wr(`IDX_TIMER1_CTL, 8'h0f, 2'b00);
        fire(6'h01);
        check(last_cause === 6'h02 && port_a_direction === 8'hff, "power-on");
        rd(`IDX_TIMER1_CTL, 8'h00, 2'b00);
        rd(`IDX_PWR_CTL, 8'h08, 2'b00);
    endtask : t_power_on

    task automatic t_wdt_wake();
        wr(`IDX_OPT_CTL, 8'h5a, 2'b00);
        wr(`IDX_TIMER1_CTL, 8'h15, 2'b00);
        sleep_pc <= 13'h0100;
        fire(6'h20);
        check(program_counter === 13'h0101 && last_cause === 6'h20, "wdt wake");
        rd(`IDX_OPT_CTL, 8'h5a, 2'b00);
        rd(`IDX_TIMER1_CTL, 8'h15, 2'b00);
    endtask : t_wdt_wake

    // Interrupt wake with and without the global enable
    task automatic t_irq_wake();
        for (int g = 1; g >= 0; g--)
        begin
            wr(`IDX_INTERRUPT_CONTROL_REG_REG, g ? 8'h80 : 8'h00, 2'b00);
            sleep_pc <= 13'h0200;
            wake_interrupt_control_reg_flags <= 8'h01;
            wake_pir_flags <= 8'h20;
            fire(6'h10);
            check(program_counter === (g ? 13'h0004 : 13'h0201), "irq wake pc");
            rd(`IDX_INTERRUPT_CONTROL_REG_REG, g ? 8'h81 : 8'h01, 2'b00);
            rd(`IDX_PIR_FLAGS, 8'h20, 2'b00);
            rd(`IDX_RX_STATUS, 8'h01, 2'b00);
        end
    endtask : t_irq_wake

    task automatic test_done();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // ----------------
    // Clock, watchdog and main sequence
    // ----------------
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // A run takes a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        $display("CHECK FAILED %0t timeout", $time);
        test_done();
    end

    initial
    begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'h1;
        {ev, wake_interrupt_control_reg_flags, wake_pir_flags, sleep_pc} = '0;
        err_total = 0;
        checked = 0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_after_reset();
        t_refuse();
        t_other_reset();
        t_brownout();
        t_power_on();
        t_wdt_wake();
        t_irq_wake();
        test_done();
    end
endmodule : test_reset_init_register_state
